//--- verilog/cieb_map.svh
// register offsets, field positions and reset values of the can interrupt enable bank
`ifndef CIEB_MAP_SVH
`define CIEB_MAP_SVH
`define CIEB_ADDR_W        4
`define CIEB_OFF_ENABLE    4'h0
`define CIEB_OFF_CONFIG    4'h4
`define CIEB_OFF_STATUS    4'h8
`define CIEB_ENABLE_RST    8'h00
`define CIEB_CONFIG_RST    8'h00
`define CIEB_BIT_INVALID   7
`define CIEB_BIT_WAKEUP    6
`define CIEB_BIT_ERROR     5
`define CIEB_BIT_TX_TWO    4
`define CIEB_BIT_TX_ONE    3
`define CIEB_BIT_TX_ZERO   2
`define CIEB_BIT_RX_ONE    1
`define CIEB_BIT_RX_ZERO   0
`define CIEB_CFG_MODE_LSB  0
`define CIEB_CFG_GLOBAL    2
`define CIEB_CFG_PRIO      3
`define CIEB_RESP_OKAY     2'b00
`define CIEB_RESP_SLVERR   2'b10
`endif

//--- verilog/cieb_pkg.sv
// types of the can interrupt enable bank
package cieb_pkg;
    typedef enum logic [1:0] {
        CIEB_MODE_0 = 2'h0,
        CIEB_MODE_1 = 2'h1,
        CIEB_MODE_2 = 2'h2
    } cieb_mode_t;
endpackage

//--- verilog/cieb_gate.sv
// mode-dependent masking of enable bits and request gating
module cieb_gate
    import cieb_pkg::*;
(
    // mode and raw register
    input  wire logic [1:0] mode,
    input  wire logic [7:0] raw_enable,
    // request side
    input  wire logic [7:0] request_flags,
    input  wire logic       peripheral_global_enable,
    input  wire logic       priority_levels_enable,
    // results
    output logic      [7:0] visible_enable,
    output logic      [7:0] gated_requests,
    output logic            irq_out
);
    import cieb_pkg::*;
    `include "cieb_map.svh"

    wire        legacy_mode = (mode == CIEB_MODE_0);
    wire        fifo_mode   = (mode == CIEB_MODE_2);
    wire [7:0]  mode_mask;

    // tx one/zero forced low outside mode 0, bit 0 only exists in modes 0 and 2
    assign mode_mask = {4'hf, legacy_mode, legacy_mode, 1'b1, legacy_mode | fifo_mode}; // RL8 RL9 RL10
    assign visible_enable = raw_enable & mode_mask; // RL4 RL5 RL6 RL10
    assign gated_requests = visible_enable & request_flags; // RL1 RL2 RL3 RL12
    // without priority levels the global peripheral enable must also be set
    assign irq_out = (|gated_requests) & (priority_levels_enable | peripheral_global_enable); // RL11
endmodule

//--- verilog/cieb_top.sv
// axi4-lite register slave for the can interrupt enable bank
// Function
// RL1: bit 7 gates invalid message request
// RL2: bit 6 gates bus wakeup request
// RL3: bit 5 gates bus error request
// RL4: mode 0: bit 4 enables tx buffer two
// RL5: modes 1,2: bit 4 enables any tx buffer
// RL6: mode 0: bits 1,0 enable rx buffers
// RL7: implemented bits read/write, reset to zero
// RL8: unimplemented bits read as zero
// RL9: modes 1,2: bits 3,2 forced zero
// RL10: modes 1,2 rx any; mode 2 fifo watermark
// RL11: no priority: global enable also required
// RL12: request needs flag and enable both set
module cieb_top
    import cieb_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // can controller request flags, same clock
    input  wire logic [7:0]  request_flags,
    // enables and interrupt toward the processor
    output logic [7:0]       can_interrupt_enable,
    output logic [7:0]       gated_requests,
    output logic             irq_out
);
    import cieb_pkg::*;
    `include "cieb_map.svh"

    logic [7:0]  enable_raw;
    logic [7:0]  config_reg;
    logic [3:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic [7:0]  visible_enable;
    logic [1:0]  mode;
    logic [7:0]  enable_view;

    // only byte lane 0 carries register bits, the rest is dropped
    function automatic logic [7:0] cieb_merge(
        input logic [7:0]  old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        cieb_merge = s[0] ? d[7:0] : old;
    endfunction

    // one-hot select {status, config, enable}, shared by both channels
    function automatic logic [2:0] cieb_decode(
        input logic [3:0] addr
    );
        cieb_decode = {addr == `CIEB_OFF_STATUS, addr == `CIEB_OFF_CONFIG, addr == `CIEB_OFF_ENABLE};
    endfunction

    // mode 3 is reserved and treated as mode 0
    assign mode = (config_reg[1:0] == 2'h3) ? 2'h0 : config_reg[1:0];

    // config fields
    wire peripheral_global_enable = config_reg[`CIEB_CFG_GLOBAL];
    wire priority_levels_enable   = config_reg[`CIEB_CFG_PRIO];

    cieb_gate u_gate (
        .mode                     (mode),
        .raw_enable               (enable_raw),
        .request_flags            (request_flags),
        .peripheral_global_enable (peripheral_global_enable),
        .priority_levels_enable   (priority_levels_enable),
        .visible_enable           (visible_enable),
        .gated_requests           (gated_requests),
        .irq_out                  (irq_out)
    );

    // named views of the enable fields under the current mode
    wire legacy_mode            = (mode == CIEB_MODE_0);
    wire fifo_mode              = (mode == CIEB_MODE_2);
    wire invalid_message_irq_en = visible_enable[`CIEB_BIT_INVALID]; // RL1
    wire bus_wakeup_irq_en      = visible_enable[`CIEB_BIT_WAKEUP]; // RL2
    wire bus_error_irq_en       = visible_enable[`CIEB_BIT_ERROR]; // RL3
    wire tx_buffer_two_irq_en   = legacy_mode & visible_enable[`CIEB_BIT_TX_TWO]; // RL4
    wire any_tx_buffer_irq_en   = ~legacy_mode & visible_enable[`CIEB_BIT_TX_TWO]; // RL5
    wire tx_buffer_one_irq_en   = visible_enable[`CIEB_BIT_TX_ONE]; // RL9
    wire tx_buffer_zero_irq_en  = visible_enable[`CIEB_BIT_TX_ZERO]; // RL9
    wire rx_buffer_one_irq_en   = legacy_mode & visible_enable[`CIEB_BIT_RX_ONE]; // RL6
    wire any_rx_buffer_irq_en   = ~legacy_mode & visible_enable[`CIEB_BIT_RX_ONE]; // RL10
    wire rx_buffer_zero_irq_en  = legacy_mode & visible_enable[`CIEB_BIT_RX_ZERO]; // RL6
    wire fifo_watermark_irq_en  = fifo_mode & visible_enable[`CIEB_BIT_RX_ZERO]; // RL10
    assign enable_view = {
        invalid_message_irq_en,
        bus_wakeup_irq_en,
        bus_error_irq_en,
        tx_buffer_two_irq_en | any_tx_buffer_irq_en,
        tx_buffer_one_irq_en,
        tx_buffer_zero_irq_en,
        rx_buffer_one_irq_en | any_rx_buffer_irq_en,
        rx_buffer_zero_irq_en | fifo_watermark_irq_en
    };
    assign can_interrupt_enable = enable_view;

    // write channel: address and data may arrive in either order
    // bvalid blocks both readies so a second write cannot overtake the answer
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    wire [3:0]  wr_addr  = aw_take ? s_axi_awaddr : aw_addr;
    wire [31:0] wr_data  = w_take ? s_axi_wdata : w_data;
    wire [3:0]  wr_strb  = w_take ? s_axi_wstrb : w_strb;
    wire        wr_fire  = (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid;
    wire [2:0]  wr_sel   = cieb_decode(wr_addr);
    wire        wr_en    = wr_fire & wr_sel[0];
    wire        wr_cfg   = wr_fire & wr_sel[1];
    wire        wr_hit   = |wr_sel;

    // address waits here until its data turns up
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else begin
            if (aw_take) aw_addr <= s_axi_awaddr;
            aw_held <= wr_fire ? 1'b0 : (aw_held | aw_take);
        end
    end

    // data waits here until its address turns up
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            w_held <= wr_fire ? 1'b0 : (w_held | w_take);
        end
    end

    // write response stands until bready
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CIEB_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CIEB_RESP_OKAY : `CIEB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // forced bits keep storage but never show, so they return with mode 0
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_raw <= `CIEB_ENABLE_RST; // RL7
        end else if (wr_en) begin
            enable_raw <= cieb_merge(enable_raw, wr_data, wr_strb) & 8'hff; // RL7
        end
    end

    // config bits 7:4 are not stored
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            config_reg <= `CIEB_CONFIG_RST;
        end else if (wr_cfg) begin
            config_reg <= cieb_merge(config_reg, wr_data, wr_strb) & 8'h0f;
        end
    end

    // read channel, one outstanding read
    // arready falls while data stands, so the held word cannot be overwritten
    assign s_axi_arready = ~s_axi_rvalid;
    wire        ar_take        = s_axi_arvalid & s_axi_arready;
    wire [2:0]  rd_sel         = cieb_decode(s_axi_araddr);
    // read words, bits 31:8 zero except irq_out in bit 8 of the status word
    wire [31:0] rd_enable_word = {24'h0, enable_view}; // RL7 RL8
    wire [31:0] rd_config_word = {24'h0, config_reg};
    wire [31:0] rd_status_word = {23'h0, irq_out, gated_requests};
    wire        rd_hit         = |rd_sel;
    wire [31:0] rd_word        = rd_sel[0] ? rd_enable_word :
                                 rd_sel[1] ? rd_config_word :
                                 rd_sel[2] ? rd_status_word : 32'h0;

    // read data stands until rready
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `CIEB_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `CIEB_RESP_OKAY : `CIEB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- testbench/cieb_asserts.sv
// port-level assertion checker for the can interrupt enable bank
module cieb_asserts (
    // clock and reset
    input wire logic        ref_clk, nrst,
    // bus handshakes
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // interrupt path
    input wire logic [7:0]  request_flags, can_interrupt_enable, gated_requests,
    input wire logic        irq_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    gate_pair_a: assert property (gated_requests == (can_interrupt_enable & request_flags))
        else $error("gated requests not enable and flags");
    irq_cause_a: assert property (irq_out |-> (|gated_requests))
        else $error("irq without a gated request");
    reset_clear_a: assert property ($rose(nrst) |-> can_interrupt_enable == 8'h00)
        else $error("enables not clear after reset");
    enable_write_a: assert property ($changed(can_interrupt_enable) |-> s_axi_bvalid)
        else $error("enables changed without a write");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
endmodule

bind cieb_top cieb_asserts chk_i (.ref_clk, .nrst, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .request_flags, .can_interrupt_enable, .gated_requests, .irq_out);

//--- testbench/tb_top.sv
// self-checking bench for the can interrupt enable bank
`include "cieb_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] ok_r = `CIEB_RESP_OKAY, err_r = `CIEB_RESP_SLVERR;
    logic        ref_clk = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq_out;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  request_flags = 8'h00, can_interrupt_enable, gated_requests;
    int          num_errors = 0, check_count = 0, cycles = 0;
    cieb_top uut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .request_flags,
        .can_interrupt_enable, .gated_requests, .irq_out);
    always #5 ref_clk = ~ref_clk;
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // cuts a hang short, the whole run needs about 130 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // ready is raised late on purpose so the response must stand
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            begin do @(negedge ref_clk); while (!s_axi_awready); @(posedge ref_clk) s_axi_awvalid <= 1'b0; end
            begin do @(negedge ref_clk); while (!s_axi_wready); @(posedge ref_clk) s_axi_wvalid <= 1'b0; end
        join
        do @(negedge ref_clk); while (!s_axi_bvalid);
        chk("bresp", er, s_axi_bresp);
        @(posedge ref_clk) s_axi_bready <= 1'b1;
        @(posedge ref_clk) s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge ref_clk); while (!s_axi_arready);
        @(posedge ref_clk) s_axi_arvalid <= 1'b0;
        do @(negedge ref_clk); while (!s_axi_rvalid);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        @(posedge ref_clk) s_axi_rready <= 1'b1;
        @(posedge ref_clk) s_axi_rready <= 1'b0;
    endtask
    task automatic pc(input logic [7:0] g, input logic i);
        @(negedge ref_clk);
        chk("gated", g, gated_requests);
        chk("irq", i, irq_out);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h0, ok_r);
        rd(4'h4, 32'h0, ok_r);
        request_flags <= 8'hff;
        wr(4'h4, 32'h4, ok_r);
        for (int b = 0; b < 8; b++) begin
            wr(4'h0, 32'h1 << b, ok_r);
            pc(8'h1 << b, 1'b1);
        end
        wr(4'h0, 32'hff, ok_r);
        rd(4'h0, 32'hff, ok_r);
        wr(4'h4, 32'h0, ok_r);
        pc(8'hff, 1'b0);
        wr(4'h4, 32'h8, ok_r);
        pc(8'hff, 1'b1);
        request_flags <= 8'h00;
        pc(8'h00, 1'b0);
        request_flags <= 8'hff;
        $display("test gating done");
        wr(4'h4, 32'h1, ok_r);
        rd(4'h0, 32'hf2, ok_r);
        wr(4'h0, 32'hff, ok_r);
        rd(4'h0, 32'hf2, ok_r);
        wr(4'h4, 32'h2, ok_r);
        rd(4'h0, 32'hf3, ok_r);
        rd(4'h8, 32'hf3, ok_r);
        wr(4'h4, 32'h3, ok_r);
        rd(4'h4, 32'h3, ok_r);
        rd(4'h0, 32'hff, ok_r);
        wr(4'h4, 32'h0, ok_r);
        rd(4'h0, 32'hff, ok_r);
        $display("test modes done");
        wr(4'hc, 32'h0, err_r);
        rd(4'hc, 32'h0, err_r);
        rd(4'h0, 32'hff, ok_r);
        $display("test unmapped done");
        finish_test();
    end
endmodule
